// file: hw/dfs_defs.svh
// Register offsets, ranges, reset values and selection codes of the damping filter select block.
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

`define DFS_ADDR_SEL      4'h0
`define DFS_ADDR_FREQ1    4'h1
`define DFS_ADDR_SETUP1   4'h2
`define DFS_ADDR_DEPTH1   4'h3
`define DFS_ADDR_FREQ2    4'h4
`define DFS_ADDR_SETUP2   4'h5
`define DFS_ADDR_STATUS   4'h6

`define DFS_SEL_MAX       16'h0003
`define DFS_FREQ_MAX      16'h07d0
`define DFS_SETUP_MAX     16'h03e8
`define DFS_DEPTH_MAX     16'h03e8
`define DFS_FREQ_MIN_ON   16'h000a

`define DFS_RST_SEL       2'h0
`define DFS_RST_VAL       16'h0000

`define DFS_CODE_PAIR     2'h0
`define DFS_CODE_DIR      2'h3

`define DFS_PICK_PAIR     4'h3
`define DFS_PICK_POS      4'h5
`define DFS_PICK_NEG      4'ha

`endif

// file: hw/dfs_pkg.sv
// Types shared by the damping filter select block and its per-filter unit.
package dfs_pkg;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] setup;
    } dfs_cfg_t;

    typedef struct packed {
        logic        active;
        logic [15:0] freq;
        logic [15:0] setup;
    } dfs_out_t;

endpackage

// file: hw/dfs_filt_unit.sv
// One damping filter setup unit: validity of the frequency and clamp of the setup value.
`timescale 1ns/1ps
`include "dfs_defs.svh"

module dfs_filt_unit (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Stored settings and selection.
    input  wire dfs_pkg::dfs_cfg_t cfg,
    input  wire logic              chosen,
    // Settings handed to the filter.
    output      dfs_pkg::dfs_out_t out
);

    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction

    dfs_pkg::dfs_out_t next_out;
    logic [15:0]       limit;

    always_comb begin
        limit           = min16(cfg.freq, `DFS_FREQ_MAX - cfg.freq);
        next_out.active = chosen && (cfg.freq >= `DFS_FREQ_MIN_ON);
        next_out.freq   = cfg.freq;
        next_out.setup  = min16(cfg.setup, limit);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out <= '0;
        end else begin
            out <= next_out;
        end
    end

endmodule

// file: hw/dfs_top.sv
// Damping filter selection, settings registers and per-filter setup for a servo drive.
// What this block does
// - Selection code zero keeps at most two of the four filters chosen.
// - Code three picks filters one and three forward, two and four backward.
// - Damping frequency holds 0 to 2000 in 0.1 Hz steps.
// - A frequency of zero through nine switches that filter off.
// - Setup value clamps to the smaller of frequency and 2000 minus frequency.
// - Depth holds 0 to 1000 and tunes only the first filter.
// - Depth never touches filters two, three or four.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "dfs_defs.svh"

module dfs_top (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Register port.
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output      logic [15:0]       reg_rdata,
    // Command direction from the position command path, high for positive.
    input  wire logic              cmd_dir_pos,
    // Settings handed to the damping filters.
    output      logic [3:0]        filt_pick,
    output      dfs_pkg::dfs_out_t filt1,
    output      dfs_pkg::dfs_out_t filt2,
    output      logic [15:0]       depth1
);

    function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] top);
        sat16 = (v > top) ? top : v;
    endfunction

    // Setup value clamped to what a frequency allows, used by the clamp checks.
    function automatic logic [15:0] clamp_setup(input logic [15:0] s, input logic [15:0] f);
        clamp_setup = sat16(sat16(s, f), `DFS_FREQ_MAX - f);
    endfunction

    // Settings registers.
    logic [1:0]        sel;
    dfs_pkg::dfs_cfg_t cfg1;
    dfs_pkg::dfs_cfg_t cfg2;
    logic [15:0]       depth;
    logic [1:0]        next_sel;
    dfs_pkg::dfs_cfg_t next_cfg1;
    dfs_pkg::dfs_cfg_t next_cfg2;
    logic [15:0]       next_depth;

    always_comb begin
        next_sel   = sel;
        next_cfg1  = cfg1;
        next_cfg2  = cfg2;
        next_depth = depth;
        if (reg_wr) begin
            unique case (reg_addr)
                `DFS_ADDR_SEL: begin
                    next_sel = 2'(sat16(reg_wdata, `DFS_SEL_MAX));
                end
                `DFS_ADDR_FREQ1: begin
                    next_cfg1.freq = sat16(reg_wdata, `DFS_FREQ_MAX);
                end
                `DFS_ADDR_SETUP1: begin
                    next_cfg1.setup = sat16(reg_wdata, `DFS_SETUP_MAX);
                end
                `DFS_ADDR_DEPTH1: begin
                    next_depth = sat16(reg_wdata, `DFS_DEPTH_MAX);
                end
                `DFS_ADDR_FREQ2: begin
                    next_cfg2.freq = sat16(reg_wdata, `DFS_FREQ_MAX);
                end
                `DFS_ADDR_SETUP2: begin
                    next_cfg2.setup = sat16(reg_wdata, `DFS_SETUP_MAX);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel   <= `DFS_RST_SEL;
            cfg1  <= '0;
            cfg2  <= '0;
            depth <= `DFS_RST_VAL;
        end else begin
            sel   <= next_sel;
            cfg1  <= next_cfg1;
            cfg2  <= next_cfg2;
            depth <= next_depth;
        end
    end

    // Filter choice. Reserved codes one and two act like code zero so that no
    // undefined combination ever reaches the filters.
    logic [3:0]  pick;
    logic [3:0]  next_pick;
    logic [15:0] next_depth1;

    always_comb begin
        if (sel == `DFS_CODE_DIR) begin
            next_pick = cmd_dir_pos ? `DFS_PICK_POS : `DFS_PICK_NEG;
        end else begin
            next_pick = `DFS_PICK_PAIR;
        end
        next_depth1 = depth;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pick   <= '0;
            depth1 <= `DFS_RST_VAL;
        end else begin
            pick   <= next_pick;
            depth1 <= next_depth1;
        end
    end

    assign filt_pick = pick;

    // Per-filter validity and clamp, one unit for each filter with settings.
    dfs_filt_unit u_filt1 (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .cfg     (cfg1),
        .chosen  (next_pick[0]),
        .out     (filt1)
    );

    dfs_filt_unit u_filt2 (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .cfg     (cfg2),
        .chosen  (next_pick[1]),
        .out     (filt2)
    );

    // Read path: data stand in the cycle after the read strobe, zero elsewhere.
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `DFS_ADDR_SEL:    next_rdata = {14'h0000, sel};
                `DFS_ADDR_FREQ1:  next_rdata = cfg1.freq;
                `DFS_ADDR_SETUP1: next_rdata = cfg1.setup;
                `DFS_ADDR_DEPTH1: next_rdata = depth;
                `DFS_ADDR_FREQ2:  next_rdata = cfg2.freq;
                `DFS_ADDR_SETUP2: next_rdata = cfg2.setup;
                `DFS_ADDR_STATUS: next_rdata = {10'h000, filt2.active, filt1.active, pick};
                default:          next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr_freq1_low;
        reg_wr && reg_addr == `DFS_ADDR_FREQ1 && reg_wdata < `DFS_FREQ_MIN_ON;
    endsequence

    sequence s_wr_depth;
        reg_wr && reg_addr == `DFS_ADDR_DEPTH1;
    endsequence

    sequence s_wr_sel_high;
        reg_wr && reg_addr == `DFS_ADDR_SEL && reg_wdata > `DFS_SEL_MAX;
    endsequence

    sequence s_wr_ignored;
        reg_wr && reg_addr >= `DFS_ADDR_STATUS;
    endsequence

    property p_pair_pick;
        sel != `DFS_CODE_DIR |=> filt_pick == `DFS_PICK_PAIR && $countones(filt_pick) <= 2;
    endproperty
    a_pair_pick: assert property (p_pair_pick) else $error("pair mode picked wrong filters");

    property p_dir_pos;
        sel == `DFS_CODE_DIR && cmd_dir_pos |=> filt_pick == `DFS_PICK_POS;
    endproperty
    a_dir_pos: assert property (p_dir_pos) else $error("positive direction pick wrong");

    property p_dir_neg;
        sel == `DFS_CODE_DIR && !cmd_dir_pos |=> filt_pick == `DFS_PICK_NEG;
    endproperty
    a_dir_neg: assert property (p_dir_neg) else $error("negative direction pick wrong");

    property p_freq_range;
        reg_wr && reg_addr == `DFS_ADDR_FREQ1 && reg_wdata <= `DFS_FREQ_MAX |=> cfg1.freq == $past(reg_wdata);
    endproperty
    a_freq_range: assert property (p_freq_range) else $error("in-range frequency not stored");

    property p_low_off;
        s_wr_freq1_low ##1 !(reg_wr && reg_addr == `DFS_ADDR_FREQ1) |=> !filt1.active;
    endproperty
    a_low_off: assert property (p_low_off) else $error("low frequency left filter on");

    property p_clamp;
        ##1 (filt1.setup <= $past(cfg1.freq) && filt1.setup <= `DFS_FREQ_MAX - $past(cfg1.freq)
             && filt1.setup == clamp_setup($past(cfg1.setup), $past(cfg1.freq)));
    endproperty
    a_clamp: assert property (p_clamp) else $error("setup value not clamped");

    property p_depth_reach;
        s_wr_depth |=> ##1 depth1 == sat16($past(reg_wdata, 2), `DFS_DEPTH_MAX) && depth1 <= `DFS_DEPTH_MAX;
    endproperty
    a_depth_reach: assert property (p_depth_reach) else $error("depth not passed to first filter");

    property p_depth_alone;
        s_wr_depth |=> ##1 $stable(filt2);
    endproperty
    a_depth_alone: assert property (p_depth_alone) else $error("depth write disturbed second filter");

    property p_sat;
        reg_wr && reg_addr == `DFS_ADDR_SETUP2 && reg_wdata > `DFS_SETUP_MAX |=> cfg2.setup == `DFS_SETUP_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("setup write not saturated");

    // Saturation and storage of the remaining settings.
    property p_sel_sat;
        s_wr_sel_high |=> sel == 2'(`DFS_SEL_MAX);
    endproperty
    a_sel_sat: assert property (p_sel_sat) else $error("selection write not saturated");

    property p_freq_sat;
        reg_wr && reg_addr == `DFS_ADDR_FREQ1 && reg_wdata > `DFS_FREQ_MAX |=> cfg1.freq == `DFS_FREQ_MAX;
    endproperty
    a_freq_sat: assert property (p_freq_sat) else $error("frequency write not saturated");

    property p_freq2_store;
        reg_wr && reg_addr == `DFS_ADDR_FREQ2 && reg_wdata <= `DFS_FREQ_MAX |=> cfg2.freq == $past(reg_wdata);
    endproperty
    a_freq2_store: assert property (p_freq2_store) else $error("second frequency not stored");

    property p_setup1_sat;
        reg_wr && reg_addr == `DFS_ADDR_SETUP1 && reg_wdata > `DFS_SETUP_MAX |=> cfg1.setup == `DFS_SETUP_MAX;
    endproperty
    a_setup1_sat: assert property (p_setup1_sat) else $error("first setup write not saturated");

    property p_setup2_store;
        reg_wr && reg_addr == `DFS_ADDR_SETUP2 && reg_wdata <= `DFS_SETUP_MAX |=> cfg2.setup == $past(reg_wdata);
    endproperty
    a_setup2_store: assert property (p_setup2_store) else $error("second setup not stored");

    property p_depth_store;
        reg_wr && reg_addr == `DFS_ADDR_DEPTH1 && reg_wdata <= `DFS_DEPTH_MAX |=> depth == $past(reg_wdata);
    endproperty
    a_depth_store: assert property (p_depth_store) else $error("in-range depth not stored");

    property p_unmapped;
        s_wr_ignored |=> $stable(cfg1) && $stable(cfg2) && $stable(sel) && $stable(depth);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("ignored write changed a setting");

    // Filter settings follow the stored values one cycle later.
    property p_clamp2;
        ##1 filt2.setup == clamp_setup($past(cfg2.setup), $past(cfg2.freq));
    endproperty
    a_clamp2: assert property (p_clamp2) else $error("second setup value not clamped");

    property p_freq_pass;
        ##1 (filt1.freq == $past(cfg1.freq) && filt2.freq == $past(cfg2.freq));
    endproperty
    a_freq_pass: assert property (p_freq_pass) else $error("stored frequency not passed on");

    property p_low_off2;
        cfg2.freq < `DFS_FREQ_MIN_ON |=> !filt2.active;
    endproperty
    a_low_off2: assert property (p_low_off2) else $error("low frequency left second filter on");

    property p_on1;
        cfg1.freq >= `DFS_FREQ_MIN_ON && next_pick[0] |=> filt1.active;
    endproperty
    a_on1: assert property (p_on1) else $error("chosen first filter not switched on");

    property p_dir_filt1;
        sel == `DFS_CODE_DIR && !cmd_dir_pos |=> !filt1.active;
    endproperty
    a_dir_filt1: assert property (p_dir_filt1) else $error("first filter on for negative direction");

    property p_dir_filt2;
        sel == `DFS_CODE_DIR && cmd_dir_pos |=> !filt2.active;
    endproperty
    a_dir_filt2: assert property (p_dir_filt2) else $error("second filter on for positive direction");

    // Read data follow the stored frequency.
    property p_rd_freq1;
        reg_rd && reg_addr == `DFS_ADDR_FREQ1 |=> reg_rdata == $past(cfg1.freq);
    endproperty
    a_rd_freq1: assert property (p_rd_freq1) else $error("frequency read back wrong");

endmodule

// file: verif/dfs_host.sv
// Host model that writes and reads the damping settings over the register port.
`timescale 1ns/1ps
`include "dfs_defs.svh"

module dfs_host (
    // Clock.
    input  wire logic        sys_clk,
    // Register port.
    output      logic [3:0]  reg_addr,
    output      logic [15:0] reg_wdata,
    output      logic        reg_wr,
    output      logic        reg_rd
);
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Reserved selection codes are never sent; the host falls back to zero.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= (a == `DFS_ADDR_SEL && (d == 16'h0001 || d == 16'h0002)) ? 16'h0000 : d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// file: verif/dfs_top_tb.sv
// Self-checking bench for the damping filter select block.
`timescale 1ns/1ps

module dfs_top_tb;
    logic              sys_clk     = 1'b0;
    logic              sys_rst     = 1'b1;
    logic              cmd_dir_pos = 1'b0;
    logic              rd_q        = 1'b0;
    logic [3:0]        reg_addr;
    logic [15:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [15:0]       reg_rdata;
    logic [15:0]       depth1;
    logic [3:0]        filt_pick;
    logic [3:0]        pk;
    logic [15:0]       f1, s1, f2, s2, dp, sl;
    logic [32:0]       e1, e2;
    logic [15:0]       exp_q[$];
    dfs_pkg::dfs_out_t filt1, filt2;
    int                error_cnt  = 0;
    int                n_compared = 0;
    int                seed       = 83747;

    always #10 sys_clk = ~sys_clk;

    dfs_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    dfs_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_dir_pos(cmd_dir_pos),
        .filt_pick(filt_pick), .filt1(filt1), .filt2(filt2), .depth1(depth1));

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        n_compared++;
        if (seen !== expv) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    function automatic logic [32:0] fexp(input logic [15:0] f, input logic [15:0] s, input logic p);
        logic [15:0] fq;
        logic [15:0] sq;
        fq = (f > 16'h07d0) ? 16'h07d0 : f;
        sq = (s > 16'h03e8) ? 16'h03e8 : s;
        if (sq > fq) sq = fq;
        if (sq > 16'h07d0 - fq) sq = 16'h07d0 - fq;
        return {p && fq >= 16'h000a, fq, sq};
    endfunction

    // Read data belongs to the read strobe of the previous cycle.
    always @(posedge sys_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) check(33'h1, 33'h0);
            else check(33'(reg_rdata), 33'(exp_q.pop_front()));
        end
        rd_q <= reg_rd;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(4'(a), 16'h0000);
        rd(4'h6, 16'h0003);
        rd(4'hf, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            f1 = (i < 4) ? ((i < 2) ? 16'(9 + i) : 16'(1998 + i)) : 16'($unsigned($random(seed)) % 2100);
            f2 = 16'($unsigned($random(seed)) % 2100);
            s1 = (i == 0) ? 16'h0000 : 16'($unsigned($random(seed)) % 1100);
            s2 = 16'($unsigned($random(seed)) % 1100);
            dp = 16'($unsigned($random(seed)) % 1100);
            sl = 16'($random(seed) & 7);
            host.wr(4'h0, sl);
            host.wr(4'h1, f1);
            host.wr(4'h2, s1);
            host.wr(4'h3, dp);
            host.wr(4'h4, f2);
            host.wr(4'h5, s2);
            host.wr(4'h6, 16'hffff);
            host.wr(4'h9, f2);
            cmd_dir_pos <= 1'($random(seed) & 1);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            if (sl == 16'h0001 || sl == 16'h0002) sl = 16'h0000;
            if (sl > 16'h0003) sl = 16'h0003;
            pk = (sl == 16'h0003) ? (cmd_dir_pos ? 4'h5 : 4'ha) : 4'h3;
            e1 = fexp(f1, s1, pk[0]);
            e2 = fexp(f2, s2, pk[1]);
            check(33'(filt_pick), 33'(pk));
            check(filt1, e1);
            check(filt2, e2);
            check(33'(depth1), (dp > 16'h03e8) ? 33'h3e8 : 33'(dp));
            rd(4'h0, sl);
            rd(4'h1, e1[31:16]);
            rd(4'h6, {10'h000, e2[32], e1[32], pk});
        end
        repeat (3) @(posedge sys_clk);
        if (exp_q.size() != 0) error_cnt++;
        complete_run();
    end
endmodule
